// *** rtl/qdsp_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides, used for received command words.
// Assumes writer and reader share one clock and one asynchronous active-high reset.
`timescale 1ns/1ps

module qdsp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    wr_d;
    logic [AW-1:0]    rd_q;
    logic [AW-1:0]    rd_d;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Next pointer and count values.
    always_comb
    begin
        wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop)
        begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end
        else if (pop && !push)
        begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    // Pointer and count registers.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage is written without reset; empty slots are never read.
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_q] <= in_data;
        end
    end

endmodule

// *** rtl/qdsp_pkg.sv ***
// Constants shared by the serial update port of the quad DAC and its command FIFO.
// Assumes one core clock; all pin timing is resolved by oversampling in the port.
package qdsp_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int CMD_W      = 24;
    localparam int DATA_W     = 16;
    localparam int NUM_DAC    = 4;
    localparam int FIFO_DEPTH = 32;
    localparam int CNT_W      = 5;

    // ------------------------------------------------------------------
    // Command word fields
    // ------------------------------------------------------------------
    localparam int CMD_RD_BIT   = 23;
    localparam int CMD_SEL_HI   = 21;
    localparam int CMD_SEL_LO   = 19;
    localparam int CMD_ADDR_HI  = 18;
    localparam int CMD_ADDR_LO  = 16;
    localparam int CMD_HEAD_LO  = 16;

    // Register select codes.
    localparam logic [2:0] SEL_DAC   = 3'h0;
    localparam logic [2:0] SEL_RANGE = 3'h1;
    localparam logic [2:0] SEL_CTRL  = 3'h2;

    // Channel address that writes every channel at once.
    localparam logic [2:0] ADDR_ALL  = 3'h4;

    // ------------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] DAC_RESET_CODE = 16'h0000;
    localparam logic [15:0] ZERO_SCALE_BIN = 16'h0000;
    localparam logic [15:0] MID_SCALE_BIN  = 16'h8000;
    localparam logic [15:0] SIGN_FLIP      = 16'h8000;
    localparam logic [4:0]  CNT_MAX        = 5'h1f;
    localparam logic [4:0]  CNT_FULL       = 5'h18;

endpackage

// *** rtl/qdsp_port.sv ***
// Serial input and update-control port of a quad voltage-output DAC.
// Assumes every pin is asynchronous to core_clk and the shift clock is far slower.
`timescale 1ns/1ps

module qdsp_port (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        frame_sel_n,
    input  wire logic        sclk,
    input  wire logic        serial_in,
    input  wire logic        load_outputs_n,
    input  wire logic        clear_outputs_n,
    input  wire logic        bipolar_coding_strap,
    output logic             serial_out,
    output logic             cmd_ready,
    output logic      [15:0] dac_level_0,
    output logic      [15:0] dac_level_1,
    output logic      [15:0] dac_level_2,
    output logic      [15:0] dac_level_3
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Converts between a stored code and straight binary; the map is its own inverse.
    function automatic logic [15:0] qdsp_to_straight(input logic [15:0] code,
                                                     input logic bipolar, input logic strap);
        qdsp_to_straight = (bipolar && !strap) ? (code ^ qdsp_pkg::SIGN_FLIP) : code;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic [2:0] prev_q;

    // Two flops per pin; the second stage feeds logic, and a third flop on frame, shift clock and load feeds the edge strobes.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= 6'h3b;
            sync_q <= 6'h3b;
            prev_q <= 3'h7;
        end
        else
        begin
            meta_q <= {bipolar_coding_strap, clear_outputs_n, load_outputs_n,
                       serial_in, sclk, frame_sel_n};
            sync_q <= meta_q;
            prev_q <= {sync_q[3], sync_q[1], sync_q[0]};
        end
    end

    // Synchronised pin levels, one per pin.
    wire        s_frame_n = sync_q[0];
    wire        s_sclk    = sync_q[1];
    wire        s_sdi     = sync_q[2];
    wire        s_load_n  = sync_q[3];
    wire        s_clr_n   = sync_q[4];
    wire        s_strap   = sync_q[5];

    // Edge strobes, each one core cycle long.
    wire        frame_rise = s_frame_n & ~prev_q[0];
    wire        frame_fall = ~s_frame_n & prev_q[0];
    wire        sclk_rise  = s_sclk & ~prev_q[1];
    wire        sclk_fall  = ~s_sclk & prev_q[1];
    wire        load_fall  = ~s_load_n & prev_q[2];

    // ------------------------------------------------------------------
    // Shift register and serial output
    // ------------------------------------------------------------------
    logic [23:0] sr_q;
    logic [23:0] sr_d;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_d;
    logic        sdo_q;
    logic        sdo_d;
    logic        rd_load;
    logic [23:0] rd_word;
    logic        push_valid;

    // Shifting, bit counting, serial output and readback loading.
    always_comb
    begin
        sr_d  = sr_q;
        cnt_d = cnt_q;
        sdo_d = sdo_q;
        if (frame_fall)
        begin
            cnt_d = '0;
            sdo_d = sr_q[23];
        end
        if (!s_frame_n && sclk_fall)
        begin
            sr_d = {sr_q[22:0], s_sdi};
            if (cnt_q != qdsp_pkg::CNT_MAX)
            begin
                cnt_d = 5'(cnt_q + 1'b1);
            end
        end
        if (!s_frame_n && sclk_rise)
        begin
            sdo_d = sr_q[23];
        end
        if (rd_load)
        begin
            sr_d = rd_word;
        end
    end

    assign push_valid = frame_rise && (cnt_q == qdsp_pkg::CNT_FULL);

    // Shift state registers.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sr_q  <= '0;
            cnt_q <= '0;
            sdo_q <= 1'b0;
        end
        else
        begin
            sr_q  <= sr_d;
            cnt_q <= cnt_d;
            sdo_q <= sdo_d;
        end
    end

    assign serial_out = sdo_q;

    // ------------------------------------------------------------------
    // Command FIFO
    // ------------------------------------------------------------------
    logic        pop_valid;
    logic        pop_ready;
    logic [23:0] pop_word;

    qdsp_fifo #(
        .WIDTH (qdsp_pkg::CMD_W),
        .DEPTH (qdsp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .rst       (rst),
        .in_valid  (push_valid),
        .in_ready  (cmd_ready),
        .in_data   (sr_q),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_word)
    );

    // ------------------------------------------------------------------
    // Input, DAC and configuration registers
    // ------------------------------------------------------------------
    logic [15:0] in_q  [qdsp_pkg::NUM_DAC];
    logic [15:0] in_d  [qdsp_pkg::NUM_DAC];
    logic [15:0] dac_q [qdsp_pkg::NUM_DAC];
    logic [15:0] dac_d [qdsp_pkg::NUM_DAC];
    logic [15:0] lvl_q [qdsp_pkg::NUM_DAC];
    logic [15:0] lvl_d [qdsp_pkg::NUM_DAC];
    logic [3:0]  bip_q;
    logic [3:0]  bip_d;
    logic        mid_q;
    logic        mid_d;
    logic [15:0] rd_val;

    // Commands wait in the FIFO while clear is held, so it can fill.
    assign pop_ready = s_clr_n;
    wire         fire     = pop_valid & pop_ready;
    wire         cmd_rd   = pop_word[qdsp_pkg::CMD_RD_BIT];
    wire  [2:0]  cmd_sel  = pop_word[qdsp_pkg::CMD_SEL_HI:qdsp_pkg::CMD_SEL_LO];
    wire  [2:0]  cmd_addr = pop_word[qdsp_pkg::CMD_ADDR_HI:qdsp_pkg::CMD_ADDR_LO];
    wire  [15:0] cmd_data = pop_word[15:0];

    // Readback value; it is only loaded between frames.
    always_comb
    begin
        unique case (cmd_sel)
            qdsp_pkg::SEL_DAC:   rd_val = in_q[cmd_addr[1:0]];
            qdsp_pkg::SEL_RANGE: rd_val = {15'h0000, bip_q[cmd_addr[1:0]]};
            qdsp_pkg::SEL_CTRL:  rd_val = {15'h0000, mid_q};
            default:             rd_val = 16'h0000;
        endcase
    end

    assign rd_load = fire & cmd_rd & s_frame_n;
    assign rd_word = {pop_word[23:qdsp_pkg::CMD_HEAD_LO], rd_val};

    // Command execution, load transfer, clear and output coding.
    always_comb
    begin
        bip_d = bip_q;
        mid_d = mid_q;
        for (int i = 0; i < qdsp_pkg::NUM_DAC; i++)
        begin
            in_d[i]  = in_q[i];
            dac_d[i] = dac_q[i];
            if (fire && !cmd_rd && (cmd_addr == qdsp_pkg::ADDR_ALL || cmd_addr == 3'(i)))
            begin
                unique case (cmd_sel)
                    qdsp_pkg::SEL_DAC:
                    begin
                        in_d[i] = cmd_data;
                        if (!s_load_n)
                        begin
                            dac_d[i] = cmd_data;
                        end
                    end
                    qdsp_pkg::SEL_RANGE: bip_d[i] = cmd_data[0];
                    qdsp_pkg::SEL_CTRL:  mid_d    = cmd_data[0];
                    default:             bip_d    = bip_d;
                endcase
            end
            if (load_fall)
            begin
                dac_d[i] = in_d[i];
            end
            if (!s_clr_n)
            begin
                dac_d[i] = qdsp_to_straight(mid_q ? qdsp_pkg::MID_SCALE_BIN
                                                  : qdsp_pkg::ZERO_SCALE_BIN,
                                            bip_q[i], s_strap);
            end
            lvl_d[i] = qdsp_to_straight(dac_q[i], bip_q[i], s_strap);
        end
    end

    // Register file state.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bip_q <= '0;
            mid_q <= 1'b0;
            for (int i = 0; i < qdsp_pkg::NUM_DAC; i++)
            begin
                in_q[i]  <= qdsp_pkg::DAC_RESET_CODE;
                dac_q[i] <= qdsp_pkg::DAC_RESET_CODE;
                lvl_q[i] <= qdsp_pkg::DAC_RESET_CODE;
            end
        end
        else
        begin
            bip_q <= bip_d;
            mid_q <= mid_d;
            for (int i = 0; i < qdsp_pkg::NUM_DAC; i++)
            begin
                in_q[i]  <= in_d[i];
                dac_q[i] <= dac_d[i];
                lvl_q[i] <= lvl_d[i];
            end
        end
    end

    assign dac_level_0 = lvl_q[0];
    assign dac_level_1 = lvl_q[1];
    assign dac_level_2 = lvl_q[2];
    assign dac_level_3 = lvl_q[3];

endmodule

// *** tb/qdsp_host.sv ***
// Host model of the serial link: frame select, shift clock and data.
// Assumes the bench calls its tasks one at a time, just after a core clock edge.
`timescale 1ns/1ps
module qdsp_host (
    output logic      frame_sel_n,
    output logic      sclk,
    output logic      serial_in,
    input  wire logic serial_out
);
    // The link idles with the frame closed and the shift clock standing high.
    initial
    begin
        frame_sel_n = 1'b1;
        sclk = 1'b1;
        serial_in = 1'b0;
    end

    // Sends nbits of w, top bit first, and gathers serial_out at each falling edge.
    // 80 ns clock, data set ahead
    task automatic send(input logic [23:0] w, input int nbits, output logic [23:0] r);
        r = 24'h000000;
        frame_sel_n = 1'b0;
        #40;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            serial_in = w[i];
            #20;
            sclk = 1'b0;
            r = {r[22:0], serial_out};
            #40;
            sclk = 1'b1;
            #20;
        end
        serial_in = ~serial_in;
        #20;
        frame_sel_n = 1'b1;
        #200;
    endtask

    // Runs the shift clock with the frame closed, as a careless host would.
    // stray clock edges
    task automatic idle_toggle(input int n);
        for (int i = 0; i < n; i++)
        begin
            serial_in = 1'($urandom);
            #40;
            sclk = 1'b0;
            #40;
            sclk = 1'b1;
        end
    endtask
endmodule

// *** tb/qdsp_port_bench.sv ***
// Self-checking bench for the serial update port of the quad DAC.
// Assumes the host model drives the link and the monitor is bound to the port.
`timescale 1ns/1ps
module qdsp_port_bench;
    logic        core_clk;
    logic        rst;
    logic        frame_sel_n;
    logic        sclk;
    logic        serial_in;
    logic        load_outputs_n;
    logic        clear_outputs_n;
    logic        bipolar_coding_strap;
    logic        serial_out;
    logic        cmd_ready;
    wire  [15:0] lv [4];
    logic [15:0] code [4];
    logic [15:0] nxt [4];
    logic [3:0]  bip;
    logic [23:0] rx;
    logic [23:0] w;
    int          error_cnt;
    int          cmp_count;

    qdsp_port dut_u (.core_clk, .rst, .frame_sel_n, .sclk, .serial_in, .load_outputs_n,
        .clear_outputs_n, .bipolar_coding_strap, .serial_out, .cmd_ready,
        .dac_level_0(lv[0]), .dac_level_1(lv[1]), .dac_level_2(lv[2]), .dac_level_3(lv[3]));
    qdsp_host host_u (.frame_sel_n, .sclk, .serial_in, .serial_out);

    // Core clock at 200 MHz.
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Waits n edges, then steps just past the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Level seen at a channel for a stored code; bipolar twos complement flips the top bit.
    function automatic logic [15:0] lvl(input logic [15:0] c, input logic b);
        return (b && !bipolar_coding_strap) ? c ^ 16'h8000 : c;
    endfunction

    task automatic chk_all();
        for (int i = 0; i < 4; i++)
            check({8'h00, lv[i]}, {8'h00, lvl(code[i], bip[i])});
    endtask

    task automatic xfer(input logic [23:0] f);
        host_u.send(f, 24, rx);
        tick(20);
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Cuts a hung run short.
    initial
    begin
        #400000;
        error_cnt++;
        stop_test();
    end

    // Main sequence of scenarios.
    initial
    begin
        error_cnt = 0;
        cmp_count = 0;
        rst = 1'b1;
        load_outputs_n = 1'b0;
        clear_outputs_n = 1'b1;
        bipolar_coding_strap = 1'b0;
        bip = 4'h0;
        code = '{4{16'h0000}};
        void'($urandom(32'hbcc2ccef));
        tick(10);
        rst = 1'b0;
        tick(5);
        chk_all();
        // all-channel write, then random direct writes
        xfer({8'h04, 16'hffff});
        code = '{4{16'hffff}};
        chk_all();
        for (int i = 0; i < 8; i++)
        begin
            w = {5'h00, 3'($urandom % 4), 16'($urandom)};
            xfer(w);
            code[w[17:16]] = w[15:0];
            chk_all();
        end
        // channel 1 bipolar under both strap levels
        xfer({8'h09, 16'h0001});
        bip[1] = 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            bipolar_coding_strap = 1'(s);
            tick(8);
            chk_all();
        end
        // deferred writes, then one load edge
        load_outputs_n = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            nxt[i] = 16'($urandom);
            xfer({5'h00, 3'(i), nxt[i]});
        end
        chk_all();
        load_outputs_n = 1'b0;
        tick(8);
        code = nxt;
        chk_all();
        // daisy chain across stray edges, then readback
        w = {8'h03, 16'($urandom)};
        xfer(w);
        code[3] = w[15:0];
        host_u.idle_toggle(6);
        xfer({8'h82, 16'h0000});
        check(rx, w);
        xfer({8'h89, 16'h0000});
        check(rx, {8'h82, code[2]});
        // Channel 1 goes to zero, so a wrongly kept short frame would show on it.
        xfer({8'h01, 16'h0000});
        code[1] = 16'h0000;
        check(rx, {8'h89, 16'h0001});
        host_u.send({8'h01, 16'h1234}, 23, rx);
        tick(20);
        chk_all();
        for (int m = 0; m < 2; m++)
        begin
            xfer({8'h10, 15'h0000, 1'(m)});
            clear_outputs_n = 1'b0;
            tick(10);
            for (int i = 0; i < 4; i++)
                check({8'h00, lv[i]}, (m == 1) ? 24'h008000 : 24'h000000);
            clear_outputs_n = 1'b1;
            tick(4);
        end
        // buffer fills while clear stalls it, then drains in order
        clear_outputs_n = 1'b0;
        for (int i = 0; i < 33; i++)
            xfer({8'h03, 16'(i)});
        check({23'h0, cmd_ready}, 24'h000000);
        clear_outputs_n = 1'b1;
        tick(60);
        check({23'h0, cmd_ready}, 24'h000001);
        check({8'h00, lv[3]}, 24'h00001f);
        stop_test();
    end
endmodule

// *** tb/qdsp_port_monitor.sv ***
// Checker for the serial update port, watching only the port's own pins.
// Assumes one core clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module qdsp_port_monitor (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        frame_sel_n,
    input wire logic        load_outputs_n,
    input wire logic        clear_outputs_n,
    input wire logic        bipolar_coding_strap,
    input wire logic        serial_out,
    input wire logic        cmd_ready,
    input wire logic [15:0] dac_level_0,
    input wire logic [15:0] dac_level_1,
    input wire logic [15:0] dac_level_2,
    input wire logic [15:0] dac_level_3
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic [5:0] quiet_q;
    logic [5:0] quiet_d;
    logic       frame_q;
    logic       load_q;
    logic       clr_q;
    logic       strap_q;

    // Counts cycles since the last event that may move a level.
    always_comb
    begin
        quiet_d = (quiet_q == 6'h3f) ? quiet_q : quiet_q + 6'h01;
        if ((frame_sel_n && !frame_q) || (!load_outputs_n && load_q) || !clear_outputs_n ||
            (clear_outputs_n && !clr_q) || (bipolar_coding_strap != strap_q))
            quiet_d = 6'h00;
    end

    // Registers the counter and the previous pin levels.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            quiet_q <= 6'h00;
            frame_q <= 1'b1;
            load_q  <= 1'b1;
            clr_q   <= 1'b1;
            strap_q <= 1'b0;
        end
        else
        begin
            quiet_q <= quiet_d;
            frame_q <= frame_sel_n;
            load_q  <= load_outputs_n;
            clr_q   <= clear_outputs_n;
            strap_q <= bipolar_coding_strap;
        end
    end

    sequence s_clear_held;
        !clear_outputs_n [*8];
    endsequence

    sequence s_full_release;
        !cmd_ready ##0 $rose(clear_outputs_n);
    endsequence

    a_reset_clean: assert property ($fell(rst) |-> dac_level_0 == 16'h0000 &&
        dac_level_1 == 16'h0000 && dac_level_2 == 16'h0000 && dac_level_3 == 16'h0000)
        else $error("levels not zero after reset");
    a_out_in_frame: assert property ($changed(serial_out) |-> !$past(frame_sel_n, 2))
        else $error("serial output moved outside a frame");
    a_levels_quiet: assert property (quiet_q > 6'h30 |-> $stable(dac_level_0) &&
        $stable(dac_level_1) && $stable(dac_level_2) && $stable(dac_level_3))
        else $error("level moved without a cause");
    a_clear_equal: assert property (s_clear_held |-> dac_level_0 == dac_level_1 &&
        dac_level_1 == dac_level_2 && dac_level_2 == dac_level_3)
        else $error("channels differ while cleared");
    a_clear_code: assert property (s_clear_held |->
        dac_level_0 == 16'h0000 || dac_level_0 == 16'h8000)
        else $error("clear level is neither zero nor mid scale");
    a_clear_still: assert property (s_clear_held ##1 !clear_outputs_n |->
        $stable(dac_level_0))
        else $error("level moved while clear held");
    a_ready_stall: assert property ($fell(cmd_ready) |-> !$past(clear_outputs_n, 4))
        else $error("buffer filled while draining");
    a_ready_back: assert property (s_full_release |-> ##[1:8] cmd_ready)
        else $error("buffer did not drain after clear");
endmodule

bind qdsp_port qdsp_port_monitor mon_u (.core_clk, .rst, .frame_sel_n, .load_outputs_n,
    .clear_outputs_n, .bipolar_coding_strap, .serial_out, .cmd_ready, .dac_level_0,
    .dac_level_1, .dac_level_2, .dac_level_3);
